/* File: inc/syndrome_pkg.sv */
package syndrome_pkg;

    // register byte offsets
    localparam logic [11:0] STATUS_OFFSET = 12'h000;
    localparam logic [11:0] CTRL_OFFSET   = 12'h004;

    // status field positions
    localparam int VALID_BIT     = 30;
    localparam int UNCORR_BIT    = 29;
    localparam int CORR_HI       = 25;
    localparam int CORR_LO       = 24;
    localparam int POSTPONED_BIT = 23;
    localparam int IMPL_HI       = 15;
    localparam int IMPL_LO       = 8;
    localparam int PRIMARY_HI    = 7;
    localparam int PRIMARY_LO    = 0;

    // control field positions
    localparam int INJ_SYN_BIT   = 0;
    localparam int PIN_EN_BIT    = 1;

    // values after cold reset
    localparam logic [7:0]  IMPL_RESET    = 8'h00;
    localparam logic [7:0]  PRIMARY_RESET = 8'h00;
    localparam logic        INJ_SYN_RESET = 1'b0;
    localparam logic        PIN_EN_RESET  = 1'b1;
    localparam logic [31:0] RDATA_RESET   = 32'h0000_0000;

    // implemented bits of each code field
    localparam logic [7:0]  IMPL_MASK     = 8'hFF;
    localparam logic [7:0]  PRIMARY_MASK  = 8'hFF;

    // ones written to the corrected field clear it
    localparam logic [1:0]  CORR_CLEAR    = 2'h3;
    localparam logic [1:0]  CORR_NONE     = 2'h0;

    // primary fault code encoding
    localparam logic [7:0] CODE_NONE            = 8'h00;
    localparam logic [7:0] CODE_IMPL_DEFINED    = 8'h01;
    localparam logic [7:0] CODE_INT_MEM_DATA    = 8'h02;
    localparam logic [7:0] CODE_IMPL_PIN        = 8'h03;
    localparam logic [7:0] CODE_ASSERTION       = 8'h04;
    localparam logic [7:0] CODE_INT_DATAPATH    = 8'h05;
    localparam logic [7:0] CODE_ASSOC_DATA      = 8'h06;
    localparam logic [7:0] CODE_ASSOC_ADDR      = 8'h07;
    localparam logic [7:0] CODE_XLAT_DATA       = 8'h08;
    localparam logic [7:0] CODE_XLAT_ADDR       = 8'h09;
    localparam logic [7:0] CODE_PRODUCER_DATA   = 8'h0A;
    localparam logic [7:0] CODE_PRODUCER_ADDR   = 8'h0B;
    localparam logic [7:0] CODE_EXT_MEM_DATA    = 8'h0C;
    localparam logic [7:0] CODE_SW_ADDR         = 8'h0D;
    localparam logic [7:0] CODE_SW_ACCESS       = 8'h0E;
    localparam logic [7:0] CODE_SW_STATE        = 8'h0F;
    localparam logic [7:0] CODE_DATA_REG        = 8'h10;
    localparam logic [7:0] CODE_CTRL_REG        = 8'h11;
    localparam logic [7:0] CODE_ERR_RESPONSE    = 8'h12;
    localparam logic [7:0] CODE_EXT_TIMEOUT     = 8'h13;
    localparam logic [7:0] CODE_INT_TIMEOUT     = 8'h14;
    localparam logic [7:0] CODE_DEF_CMPL_UNSUP  = 8'h15;
    localparam logic [7:0] CODE_DEF_REQ_UNSUP   = 8'h16;
    localparam logic [7:0] CODE_DEF_CMPL_PASS   = 8'h17;
    localparam logic [7:0] CODE_DEF_REQ_PASS    = 8'h18;
    localparam logic [7:0] CODE_EXT_LOG         = 8'h19;
    localparam logic [7:0] CODE_OTHER_INTERNAL  = 8'h1A;
    localparam logic [7:0] CODE_MAX             = 8'h1A;

endpackage

/* File: design/syndrome_codes.sv */
// Functional notes
// - implementation-defined fault code held in status bits 15:8.
// - primary fault code held in status bits 7:0.
// - codes 0-5: none, impl, internal memory, pin, assertion, data path.
// - codes 6-9: associative data/address, translation buffer data/address.
// - codes 10-12: producer data, producer address, external memory data.
// - codes 13-15: software illegal address, access type, device state.
// - code 16 internal data register, 17 internal control register.
// - codes 18-20: error response, external timeout, internal timeout.
// - codes 21-24: deferred errors not deferrable, or passed onward.
// - code 25 logged in PCIe log, 26 other internal error.
// - primary codes above 26 are never reported.
// - only implemented code bits stored; others constant.
// - codes read zero while record invalid, unless injection implemented and ctrl bit 0 set.
// - writes ignored while uncorrected flag set and not cleared; if it is clear, while postponed flag set and not cleared.
// - with both clear, writes ignored while corrected nonzero and not cleared.
// - otherwise both code fields are plain read/write storage.
// - cold reset sets codes; error recovery reset keeps them.
// - protection follows highest-priority nonzero flag: uncorrected, postponed, corrected.
`timescale 1ns/1ns
`default_nettype none

module syndrome_codes
    import syndrome_pkg::*;
#(
    parameter bit CFI_IMPLEMENTED = 1'b1
) (
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic        err_recovery_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic        record_valid,
    input  wire logic        uncorrected_fault_flag,
    input  wire logic        postponed_fault_flag,
    input  wire logic [1:0]  corrected_fault_field,
    input  wire logic        capture_valid,
    input  wire logic [7:0]  capture_primary,
    input  wire logic [7:0]  capture_impl,
    input  wire logic        system_fault_input_pin_n,
    output var  logic [7:0]  impl_defined_code,
    output var  logic [7:0]  primary_fault_code,
    output var  logic        clear_valid,
    output var  logic        clear_uncorrected,
    output var  logic        clear_postponed,
    output var  logic        clear_corrected,
    output var  logic        write_ignored
);

    logic [31:0] prdata_r;
    logic        pready_r;
    logic        pslverr_r;
    logic [7:0]  impl_r;
    logic [7:0]  primary_r;
    logic        clr_valid_r;
    logic        clr_uncorr_r;
    logic        clr_postponed_r;
    logic        clr_corr_r;
    logic        ignored_r;
    logic        inj_syn_r;
    logic        pin_en_r;
    logic        pin_s1_r;
    logic        pin_s2_r;
    logic        pin_s3_r;
    logic        pin_lvl_r;
    logic        pin_fall;
    logic        access;
    logic        do_wr;
    logic        hit_status;
    logic        hit_ctrl;
    logic        protect;
    logic        codes_visible;
    logic [31:0] rd_nxt;
    logic [7:0]  cap_primary;
    logic [7:0]  cap_impl;

    // no code above the highest defined one leaves the block
    // defined codes pass
    function automatic logic [7:0] clamp_code(input logic [7:0] code);
        logic [7:0] m;
        m = code & PRIMARY_MASK;
        return (m > CODE_MAX) ? CODE_OTHER_INTERNAL : m;
    endfunction

    assign access     = psel && penable;
    assign do_wr      = access && pwrite && pready_r;
    assign hit_status = (paddr == STATUS_OFFSET);
    assign hit_ctrl   = (paddr == CTRL_OFFSET);

    always_comb begin
        protect = 1'b0;
        if (uncorrected_fault_flag) begin
            protect = !pwdata[UNCORR_BIT];
        end else if (postponed_fault_flag) begin
            protect = !pwdata[POSTPONED_BIT];
        end else if (corrected_fault_field != CORR_NONE) begin
            protect = (pwdata[CORR_HI:CORR_LO] != CORR_CLEAR);
        end
    end

    assign codes_visible = record_valid || (CFI_IMPLEMENTED && inj_syn_r);

    assign pin_fall = pin_lvl_r && (pin_s2_r == pin_s3_r) && !pin_s2_r;

    always_comb begin
        cap_primary = CODE_NONE;
        cap_impl    = IMPL_RESET;
        if (capture_valid) begin
            cap_primary = clamp_code(capture_primary);
            cap_impl    = capture_impl & IMPL_MASK;
        end else begin
            cap_primary = CODE_IMPL_PIN;
            cap_impl    = IMPL_RESET;
        end
    end

    always_comb begin
        rd_nxt = RDATA_RESET;
        if (hit_status) begin
            rd_nxt[VALID_BIT]       = record_valid;
            rd_nxt[UNCORR_BIT]      = uncorrected_fault_flag;
            rd_nxt[CORR_HI:CORR_LO] = corrected_fault_field;
            rd_nxt[POSTPONED_BIT]   = postponed_fault_flag;
            if (codes_visible) begin
                rd_nxt[IMPL_HI:IMPL_LO]       = impl_r;
                rd_nxt[PRIMARY_HI:PRIMARY_LO] = primary_r;
            end
        end else if (hit_ctrl) begin
            rd_nxt[INJ_SYN_BIT] = inj_syn_r;
            rd_nxt[PIN_EN_BIT]  = pin_en_r;
        end
    end

    // apb answer, one wait state
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= RDATA_RESET;
        end else begin
            pready_r  <= access && !pready_r;
            pslverr_r <= access && !pready_r && !hit_status && !hit_ctrl;
            if (access && !pready_r && !pwrite) begin
                prdata_r <= rd_nxt;
            end
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            impl_r    <= IMPL_RESET;
            primary_r <= PRIMARY_RESET;
        end else if (capture_valid || (pin_fall && pin_en_r)) begin
            impl_r    <= cap_impl;
            primary_r <= cap_primary;
        end else if (do_wr && hit_status && !protect) begin
            impl_r    <= pwdata[IMPL_HI:IMPL_LO] & IMPL_MASK;
            primary_r <= clamp_code(pwdata[PRIMARY_HI:PRIMARY_LO]);
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            inj_syn_r <= INJ_SYN_RESET;
            pin_en_r  <= PIN_EN_RESET;
        end else if (do_wr && hit_ctrl) begin
            inj_syn_r <= pwdata[INJ_SYN_BIT];
            pin_en_r  <= pwdata[PIN_EN_BIT];
        end
    end

    // clear requests to the flag owner
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            clr_valid_r     <= 1'b0;
            clr_uncorr_r    <= 1'b0;
            clr_postponed_r <= 1'b0;
            clr_corr_r      <= 1'b0;
            ignored_r       <= 1'b0;
        end else begin
            clr_valid_r     <= do_wr && hit_status && pwdata[VALID_BIT];
            clr_uncorr_r    <= do_wr && hit_status && pwdata[UNCORR_BIT];
            clr_postponed_r <= do_wr && hit_status && pwdata[POSTPONED_BIT];
            clr_corr_r      <= do_wr && hit_status
                               && (pwdata[CORR_HI:CORR_LO] == CORR_CLEAR);
            ignored_r       <= do_wr && hit_status && protect;
        end
    end

    // pin synchroniser, change taken when stages two and three agree
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_s1_r  <= 1'b1;
            pin_s2_r  <= 1'b1;
            pin_s3_r  <= 1'b1;
            pin_lvl_r <= 1'b1;
        end else begin
            pin_s1_r <= system_fault_input_pin_n;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            if (pin_s2_r == pin_s3_r) begin
                pin_lvl_r <= pin_s3_r;
            end
        end
    end

    assign prdata             = prdata_r;
    assign pready             = pready_r;
    assign pslverr            = pslverr_r;
    assign impl_defined_code  = impl_r;
    assign primary_fault_code = primary_r;
    assign clear_valid        = clr_valid_r;
    assign clear_uncorrected  = clr_uncorr_r;
    assign clear_postponed    = clr_postponed_r;
    assign clear_corrected    = clr_corr_r;
    assign write_ignored      = ignored_r;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    logic no_capture;
    assign no_capture = !capture_valid && !(pin_fall && pin_en_r);

    a_uncorr_protect: assert property (
        do_wr && hit_status && no_capture && uncorrected_fault_flag
        && !pwdata[UNCORR_BIT]
        |=> $stable(primary_r) && $stable(impl_r) && write_ignored)
        else $error("code write taken while uncorrected flag set");

    a_postponed_protect: assert property (
        do_wr && hit_status && no_capture && !uncorrected_fault_flag
        && postponed_fault_flag && !pwdata[POSTPONED_BIT]
        |=> $stable(primary_r) && $stable(impl_r))
        else $error("code write taken while postponed flag set");

    a_corr_protect: assert property (
        do_wr && hit_status && no_capture && !uncorrected_fault_flag
        && !postponed_fault_flag && (corrected_fault_field != CORR_NONE)
        && (pwdata[CORR_HI:CORR_LO] != CORR_CLEAR)
        |=> $stable(primary_r) && $stable(impl_r))
        else $error("code write taken while corrected field set");

    a_plain_write: assert property (
        do_wr && hit_status && no_capture && !uncorrected_fault_flag
        && !postponed_fault_flag && (corrected_fault_field == CORR_NONE)
        |=> impl_r == ($past(pwdata[IMPL_HI:IMPL_LO]) & IMPL_MASK)
            && primary_r == clamp_code($past(pwdata[PRIMARY_HI:PRIMARY_LO])))
        else $error("unprotected code write not stored");

    a_code_range: assert property (
        primary_r <= CODE_MAX)
        else $error("reserved primary code held");

    a_hidden_read: assert property (
        access && !pready_r && !pwrite && hit_status && !codes_visible
        |=> prdata_r[IMPL_HI:PRIMARY_LO] == 16'h0000 && pready_r)
        else $error("codes shown while record invalid");

    a_capture_wins: assert property (
        capture_valid
        |=> primary_r == clamp_code($past(capture_primary))
            && impl_r == ($past(capture_impl) & IMPL_MASK))
        else $error("captured syndrome lost");

    a_pin_code: assert property (
        !capture_valid && pin_fall && pin_en_r |=> primary_r == CODE_IMPL_PIN)
        else $error("pin fault not recorded as pin code");

    a_recovery_keep: assert property (
        err_recovery_rst && no_capture && !(do_wr && hit_status)
        |=> $stable(primary_r) && $stable(impl_r))
        else $error("codes changed by recovery reset");

    a_ready_pulse: assert property (
        pready_r |=> !pready_r)
        else $error("ready held longer than one cycle");

    a_assoc_codes: assert property (
        capture_valid && capture_primary >= CODE_ASSOC_DATA
        && capture_primary <= CODE_XLAT_ADDR
        |=> primary_r == $past(capture_primary))
        else $error("associative or translation code altered");

    a_producer_codes: assert property (
        capture_valid && capture_primary >= CODE_PRODUCER_DATA
        && capture_primary <= CODE_EXT_MEM_DATA
        |=> primary_r == $past(capture_primary))
        else $error("producer or external memory code altered");

    a_software_codes: assert property (
        capture_valid && capture_primary >= CODE_SW_ADDR
        && capture_primary <= CODE_SW_STATE
        |=> primary_r == $past(capture_primary))
        else $error("software fault code altered");

    a_register_codes: assert property (
        capture_valid && capture_primary >= CODE_DATA_REG
        && capture_primary <= CODE_CTRL_REG
        |=> primary_r == $past(capture_primary))
        else $error("register fault code altered");

    a_timeout_codes: assert property (
        capture_valid && capture_primary >= CODE_ERR_RESPONSE
        && capture_primary <= CODE_INT_TIMEOUT
        |=> primary_r == $past(capture_primary))
        else $error("response or timeout code altered");

    a_deferred_codes: assert property (
        capture_valid && capture_primary >= CODE_DEF_CMPL_UNSUP
        && capture_primary <= CODE_DEF_REQ_PASS
        |=> primary_r == $past(capture_primary))
        else $error("deferred error code altered");

    a_log_codes: assert property (
        capture_valid && capture_primary >= CODE_EXT_LOG
        && capture_primary <= CODE_OTHER_INTERNAL
        |=> primary_r == $past(capture_primary))
        else $error("log or other internal code altered");

    a_clear_pulses: assert property (
        do_wr && hit_status
        |=> clear_valid == $past(pwdata[VALID_BIT])
            && clear_uncorrected == $past(pwdata[UNCORR_BIT])
            && clear_postponed == $past(pwdata[POSTPONED_BIT])
            && clear_corrected == ($past(pwdata[CORR_HI:CORR_LO]) == CORR_CLEAR))
        else $error("clear request does not follow the write");

    a_no_stray_clear: assert property (
        !(do_wr && hit_status)
        |=> !clear_valid && !clear_uncorrected && !clear_postponed
            && !clear_corrected && !write_ignored)
        else $error("clear or ignore pulse without a status write");

    a_unmapped_error: assert property (
        access && !pready_r && !hit_status && !hit_ctrl
        |=> pready_r && pslverr_r)
        else $error("unmapped access not answered with error");

endmodule // syndrome_codes

`default_nettype wire

/* File: tb/syndrome_codes_tb.sv */
`timescale 1ns/1ns
`default_nettype none

module syndrome_codes_tb;
    import syndrome_pkg::*;

    logic        mclk;
    logic        sys_rst;
    logic        err_recovery_rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        record_valid;
    logic        uncorrected_fault_flag;
    logic        postponed_fault_flag;
    logic [1:0]  corrected_fault_field;
    logic        capture_valid;
    logic [7:0]  capture_primary;
    logic [7:0]  capture_impl;
    logic        system_fault_input_pin_n;
    logic [7:0]  impl_defined_code;
    logic [7:0]  primary_fault_code;
    int          bad_count;
    int          check_count;
    int          cycles;
    logic [31:0] rd;
    logic        err;
    logic        ign;
    logic [3:0]  clr;
    logic        ign_w;
    logic        clr_v_w;
    logic        clr_u_w;
    logic        clr_p_w;
    logic        clr_c_w;

    syndrome_codes syndrome_codes_inst (
        .mclk(mclk), .sys_rst(sys_rst), .err_recovery_rst(err_recovery_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .record_valid(record_valid),
        .uncorrected_fault_flag(uncorrected_fault_flag),
        .postponed_fault_flag(postponed_fault_flag),
        .corrected_fault_field(corrected_fault_field), .capture_valid(capture_valid),
        .capture_primary(capture_primary), .capture_impl(capture_impl),
        .system_fault_input_pin_n(system_fault_input_pin_n),
        .impl_defined_code(impl_defined_code), .primary_fault_code(primary_fault_code),
        .clear_valid(clr_v_w), .clear_uncorrected(clr_u_w), .clear_postponed(clr_p_w),
        .clear_corrected(clr_c_w), .write_ignored(ign_w)
    );

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            report_and_stop();
        end
    end

    task report_and_stop;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask

    task chk1(input string name, input logic exp, input logic got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s expected %b seen %b", name, exp, got);
        end
    endtask

    task apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) begin
            @(posedge mclk);
        end
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
        ign = ign_w;
        clr = {clr_v_w, clr_u_w, clr_p_w, clr_c_w};
    endtask

    task flags(input logic v, input logic u, input logic p, input logic [1:0] c);
        @(posedge mclk);
        record_valid           <= v;
        uncorrected_fault_flag <= u;
        postponed_fault_flag   <= p;
        corrected_fault_field  <= c;
    endtask

    task t_reset;
        chk("impl after reset", {24'h0, IMPL_RESET}, {24'h0, impl_defined_code});
        chk("primary after reset", 32'h0, {24'h0, primary_fault_code});
        apb(1'b0, STATUS_OFFSET, 32'h0);
        chk("hidden codes", 32'h0, rd & 32'h0000_FFFF);
        apb(1'b0, CTRL_OFFSET, 32'h0);
        chk("ctrl reset", {30'h0, PIN_EN_RESET, INJ_SYN_RESET}, rd);
        apb(1'b0, 12'h008, 32'h0);
        chk1("unmapped error", 1'b1, err);
        chk("unmapped read", 32'h0, rd);
    endtask

    task t_plain;
        flags(1'b1, 1'b0, 1'b0, 2'b00);
        apb(1'b1, STATUS_OFFSET, 32'h0000_5A0C);
        chk1("plain write ignored", 1'b0, ign);
        chk1("plain error", 1'b0, err);
        chk("plain pulses", 32'h0, {28'h0, clr});
        chk("impl out", 32'h5A, {24'h0, impl_defined_code});
        chk("primary out", 32'h0C, {24'h0, primary_fault_code});
        apb(1'b0, STATUS_OFFSET, 32'h0);
        chk("status codes", 32'h0000_5A0C, rd & 32'h0000_FFFF);
    endtask

    task t_clear;
        logic [31:0] w;
        flags(1'b1, 1'b1, 1'b0, 2'b10);
        apb(1'b0, STATUS_OFFSET, 32'h0);
        w = {1'b0, rd[30:29], 3'b0, {2{|rd[25:24]}}, rd[23], 23'h0};
        apb(1'b1, STATUS_OFFSET, w);
        chk1("clear write ignored", 1'b0, ign);
        chk("clear pulses", 32'hD, {28'h0, clr});
        chk("codes cleared", 32'h0, {16'h0, impl_defined_code, primary_fault_code});
        flags(1'b1, 1'b0, 1'b0, 2'b00);
    endtask

    task automatic t_protect;
        logic [7:0]  tbl [8] = '{8'h81, 8'h88, 8'h41, 8'h44, 8'h11, 8'h22, 8'hC5, 8'h54};
        logic [7:0]  e;
        logic [7:0]  ei;
        logic [7:0]  ep;
        logic [31:0] w;
        ei = 8'h5A;
        ep = 8'h0C;
        for (int i = 0; i < 8; i++) begin
            e = tbl[i];
            flags(1'b1, e[7], e[6], e[5:4]);
            w = {2'b0, e[3], 3'b0, {2{e[1]}}, e[2], 7'h0, 8'h40 + 8'(i), 8'(i + 1)};
            apb(1'b1, STATUS_OFFSET, w);
            if (!e[0]) begin
                ei = 8'h40 + 8'(i);
                ep = 8'(i + 1);
            end
            chk1("write ignored", e[0], ign);
            chk("impl kept", {24'h0, ei}, {24'h0, impl_defined_code});
            chk("primary kept", {24'h0, ep}, {24'h0, primary_fault_code});
        end
        flags(1'b1, 1'b0, 1'b0, 2'b00);
    endtask

    task t_codes;
        for (int c = 0; c <= 28; c++) begin
            @(posedge mclk);
            capture_valid   <= 1'b1;
            capture_primary <= 8'(c);
            capture_impl    <= 8'(255 - c);
            @(posedge mclk);
            capture_valid <= 1'b0;
            @(negedge mclk);
            chk("captured primary", (c > 26) ? {24'h0, CODE_MAX} : 32'(c),
                {24'h0, primary_fault_code});
            chk("captured impl", 32'(255 - c), {24'h0, impl_defined_code});
        end
        apb(1'b0, STATUS_OFFSET, 32'h0);
        chk("status after capture", 32'h0000_E31A, rd & 32'h0000_FFFF);
    endtask

    task t_visibility;
        flags(1'b0, 1'b0, 1'b0, 2'b00);
        apb(1'b0, STATUS_OFFSET, 32'h0);
        chk("invalid record view", 32'h0, rd & 32'h0000_FFFF);
        apb(1'b1, CTRL_OFFSET, 32'h3);
        apb(1'b0, STATUS_OFFSET, 32'h0);
        chk("injection view", 32'h0000_E31A, rd & 32'h0000_FFFF);
        apb(1'b1, CTRL_OFFSET, 32'h2);
    endtask

    task t_pin;
        int n;
        apb(1'b1, CTRL_OFFSET, 32'h0);
        @(posedge mclk);
        system_fault_input_pin_n <= 1'b0;
        repeat (8) @(negedge mclk);
        chk("pin masked", {24'h0, CODE_MAX}, {24'h0, primary_fault_code});
        @(posedge mclk);
        system_fault_input_pin_n <= 1'b1;
        repeat (8) @(posedge mclk);
        apb(1'b1, CTRL_OFFSET, 32'h2);
        @(posedge mclk);
        system_fault_input_pin_n <= 1'b0;
        n = 0;
        @(negedge mclk);
        while (primary_fault_code !== CODE_IMPL_PIN && n < 20) begin
            @(negedge mclk);
            n++;
        end
        chk("pin code", {24'h0, CODE_IMPL_PIN}, {24'h0, primary_fault_code});
        chk("pin impl", {24'h0, IMPL_RESET}, {24'h0, impl_defined_code});
        @(posedge mclk);
        system_fault_input_pin_n <= 1'b1;
        apb(1'b1, CTRL_OFFSET, 32'h1);
    endtask

    task t_resets;
        apb(1'b1, STATUS_OFFSET, 32'h0000_A50D);
        @(posedge mclk);
        err_recovery_rst <= 1'b1;
        repeat (3) @(posedge mclk);
        err_recovery_rst <= 1'b0;
        @(negedge mclk);
        chk("primary kept", 32'h0D, {24'h0, primary_fault_code});
        chk("impl kept", 32'hA5, {24'h0, impl_defined_code});
        @(posedge mclk);
        sys_rst <= 1'b1;
        @(posedge mclk);
        sys_rst <= 1'b0;
        @(negedge mclk);
        chk("primary cold", {24'h0, PRIMARY_RESET}, {24'h0, primary_fault_code});
        chk("impl cold", {24'h0, IMPL_RESET}, {24'h0, impl_defined_code});
        apb(1'b0, CTRL_OFFSET, 32'h0);
        chk("ctrl cold", {30'h0, PIN_EN_RESET, INJ_SYN_RESET}, rd);
    endtask

    initial begin
        sys_rst = 1'b1;
        err_recovery_rst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        record_valid = 1'b0;
        uncorrected_fault_flag = 1'b0;
        postponed_fault_flag = 1'b0;
        corrected_fault_field = 2'b00;
        capture_valid = 1'b0;
        capture_primary = 8'h00;
        capture_impl = 8'h00;
        system_fault_input_pin_n = 1'b1;
        bad_count = 0;
        check_count = 0;
        cycles = 0;
        repeat (4) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (4) @(negedge mclk);
        t_reset();
        t_plain();
        t_protect();
        t_clear();
        t_codes();
        t_visibility();
        t_pin();
        t_resets();
        report_and_stop();
    end

endmodule // syndrome_codes_tb

`default_nettype wire
